// *** lane_map_pkg.sv ***
// Shared constants and types for the display port interface lane mapper
package lane_map_pkg;

    // ==========================================
    // Lane geometry
    localparam int unsigned LANES     = 4;
    localparam int unsigned LANE_IDX_W = 2;
    localparam int unsigned SYM_W_DEF = 10;

    // HDMI/DVI encoder lane that carries the TMDS clock
    localparam logic [1:0] TMDS_CLK_LANE = 2'h3;

    // Type-C alternate mode lane counts
    localparam logic [2:0] TYPEC_LANES_NARROW = 3'h2;
    localparam logic [2:0] TYPEC_LANES_WIDE   = 3'h4;

    // ==========================================
    // Reset values
    localparam logic [3:0] PIN_EN_RST = 4'h0;

    // ==========================================
    // Static port configuration
    typedef struct packed {
        logic reverse;     // Lane reversal on a combo port
        logic hdmi;        // 1 = HDMI/DVI, 0 = DisplayPort
        logic typec;       // Port wired to the type-C lane mux
        logic dsi_sel;     // Combo port drives the DSI transmitter output
        logic two_lane;    // Type-C alternate mode with two lanes only
    } port_cfg_t;

    localparam port_cfg_t CFG_RST = '{reverse: 1'b0, hdmi: 1'b0, typec: 1'b0,
                                      dsi_sel: 1'b0, two_lane: 1'b0};

endpackage

// *** lane_mapper.sv ***
// Lane steering from encoder lanes or DSI transmitter onto four package data pins
//
// What this block does
// RULE_01 - A combo port in DisplayPort mode puts lane n on pin n, or lane 3-n on pin n when reversed.
// RULE_02 - HDMI/DVI puts the TMDS clock on pin 3 and data 0,1,2 on pins 2,1,0, or data 2,1,0 on pins 3,2,1 and the clock on pin 0 when reversed.
// RULE_03 - A type-C port never reorders lanes, since the external type-C lane mux does reversal and orientation.
// RULE_04 - The first two combo ports select either the DSI transmitter or the display-port encoder onto the pins, never both.
// RULE_05 - Software changes the DSI or display-port selection only while the port is inactive.
// RULE_06 - A type-C port in DisplayPort alternate mode drives either two or four data lanes.
// RULE_07 - Reversal and output selection are static and the applied mapping updates only while the port is disabled.
`timescale 1ns/1ps

module lane_mapper #(
    parameter int unsigned SYM_W       = lane_map_pkg::SYM_W_DEF,
    parameter bit          DSI_CAPABLE = 1'b1
) (
    // Clock, reset, enable
    input  wire logic                          mclk_i,
    input  wire logic                          resetn_i,
    input  wire logic                          ce_i,
    // Static configuration
    input  wire logic                          port_enable_i,
    input  wire lane_map_pkg::port_cfg_t       cfg_i,
    // Encoder lanes: DP lanes 0-3, or TMDS data 0-2 plus clock on lane 3
    input  wire logic [3:0][SYM_W-1:0]         enc_lane_i,
    // DSI transmitter output, already in pin order
    input  wire logic [3:0][SYM_W-1:0]         dsi_pin_i,
    // Package data pins
    output logic      [3:0][SYM_W-1:0]         pin_data_o,
    output logic      [3:0]                    pin_en_o,
    // Applied configuration
    output lane_map_pkg::port_cfg_t            cfg_applied_o,
    output logic                               dsi_active_o
);

    // ==========================================
    // Encoder lane feeding a given pin
    function automatic logic [1:0] src_lane(input lane_map_pkg::port_cfg_t c,
                                            input logic [1:0] pin);
        logic [1:0] res;
        res = pin;
        if (c.typec)
        begin
            res = pin;                                         // RULE_03
        end
        else if (c.hdmi)
        begin
            if (c.reverse)
            begin
                res = (pin == 2'h0) ? lane_map_pkg::TMDS_CLK_LANE : pin - 2'h1;  // RULE_02
            end
            else
            begin
                res = (pin == 2'h3) ? lane_map_pkg::TMDS_CLK_LANE : 2'h2 - pin;  // RULE_02
            end
        end
        else if (c.reverse)
        begin
            res = 2'h3 - pin;                                  // RULE_01
        end
        return res;
    endfunction

    // ==========================================
    // Configuration clean-up
    // Drops settings the port cannot honour
    function automatic lane_map_pkg::port_cfg_t clean_cfg(input lane_map_pkg::port_cfg_t c);
        lane_map_pkg::port_cfg_t res;
        res = c;
        // DSI only exists on capable combo ports
        res.dsi_sel  = c.dsi_sel & DSI_CAPABLE & ~c.typec;      // RULE_04
        // Reversal is left to the lane mux on type-C
        res.reverse  = c.reverse & ~c.typec;                    // RULE_03
        // Narrow alternate mode only exists on type-C
        res.two_lane = c.two_lane & c.typec;                    // RULE_06
        return res;
    endfunction

    // ==========================================
    // Pin drive decision
    function automatic logic pin_on(input lane_map_pkg::port_cfg_t c,
                                    input logic                    enable,
                                    input logic [1:0]              pin);
        logic res;
        res = enable;
        if (c.two_lane && ({1'b0, pin} >= lane_map_pkg::TYPEC_LANES_NARROW))
        begin
            res = 1'b0;                                         // RULE_06
        end
        return res;
    endfunction

    // ==========================================
    // Symbol for one pin
    function automatic logic [SYM_W-1:0] pin_symbol(input lane_map_pkg::port_cfg_t c,
                                                    input logic [3:0][SYM_W-1:0] enc,
                                                    input logic [3:0][SYM_W-1:0] dsi,
                                                    input logic [1:0]            pin);
        logic [SYM_W-1:0] res;
        if (c.dsi_sel)
        begin
            // Only one source reaches the pins
            res = dsi[pin];                                     // RULE_04
        end
        else
        begin
            res = enc[src_lane(c, pin)];
        end
        return res;
    endfunction

    // ==========================================
    // Configuration hold
    lane_map_pkg::port_cfg_t cfg_r;
    lane_map_pkg::port_cfg_t cfg_nxt;
    logic                    dsi_active_r;
    logic                    dsi_active_nxt;

    // Loads only while the port is stopped
    always_comb
    begin
        cfg_nxt        = cfg_r;
        dsi_active_nxt = dsi_active_r;
        if (!port_enable_i)
        begin
            cfg_nxt        = clean_cfg(cfg_i);                  // RULE_07
            dsi_active_nxt = cfg_nxt.dsi_sel;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_r <= lane_map_pkg::CFG_RST;
        end
        else if (ce_i)
        begin
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dsi_active_r <= lane_map_pkg::CFG_RST.dsi_sel;
        end
        else if (ce_i)
        begin
            dsi_active_r <= dsi_active_nxt;
        end
    end

    // ==========================================
    // Pin steering
    logic [3:0][SYM_W-1:0] pin_data_r;
    logic [3:0][SYM_W-1:0] pin_data_nxt;
    logic [3:0]            pin_en_r;
    logic [3:0]            pin_en_nxt;

    // Undriven pins carry zero symbols
    always_comb
    begin
        pin_data_nxt = '0;
        pin_en_nxt   = lane_map_pkg::PIN_EN_RST;
        for (int p = 0; p < lane_map_pkg::LANES; p++)
        begin
            pin_en_nxt[p] = pin_on(cfg_r, port_enable_i, p[1:0]);
            if (pin_en_nxt[p])
            begin
                pin_data_nxt[p] = pin_symbol(cfg_r, enc_lane_i, dsi_pin_i, p[1:0]);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_data_r <= '0;
        end
        else if (ce_i)
        begin
            pin_data_r <= pin_data_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_en_r <= lane_map_pkg::PIN_EN_RST;
        end
        else if (ce_i)
        begin
            pin_en_r <= pin_en_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign pin_data_o    = pin_data_r;
    assign pin_en_o      = pin_en_r;
    assign cfg_applied_o = cfg_r;
    assign dsi_active_o  = dsi_active_r;

endmodule

// *** lane_mapper_sva.sv ***
// Port assertions for the lane mapper
`timescale 1ns/1ps
module lane_mapper_sva #(parameter int unsigned SYM_W = 10) (
    // Clock, reset, enable
    input wire logic                    mclk_i,
    input wire logic                    resetn_i,
    input wire logic                    ce_i,
    // Configuration
    input wire logic                    port_enable_i,
    input wire logic                    dsi_active_o,
    input wire lane_map_pkg::port_cfg_t cfg_i,
    input wire lane_map_pkg::port_cfg_t cfg_applied_o,
    // Lanes and pins
    input wire logic [3:0][SYM_W-1:0]   enc_lane_i,
    input wire logic [3:0][SYM_W-1:0]   dsi_pin_i,
    input wire logic [3:0][SYM_W-1:0]   pin_data_o,
    input wire logic [3:0]              pin_en_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    lane_map_pkg::port_cfg_t c;
    logic on, run;
    assign c = cfg_applied_o;
    assign on = ce_i && port_enable_i;
    assign run = on && !c.dsi_sel;
    // ==========================================
    // Mapping
    a_dp_order: assert property (
        run && !c.hdmi |=> pin_data_o[0] == $past(enc_lane_i[c.reverse ? 3 : 0])
    ) else $error("dp order");
    a_tmds_order: assert property (
        run && c.hdmi |=> pin_data_o[3] == $past(enc_lane_i[c.reverse ? 2 : 3])
    ) else $error("tmds order");
    a_typec_pass: assert property (
        run && c.typec |=> pin_data_o[1] == $past(enc_lane_i[1])
    ) else $error("typec order");
    a_dsi_pick: assert property (
        on && c.dsi_sel |=> pin_data_o[2] == $past(dsi_pin_i[2]) && dsi_active_o
    ) else $error("dsi path");
    a_lane_count: assert property (
        on |=> pin_en_o == ($past(c.two_lane) ? 4'h3 : 4'hf)
    ) else $error("lane count");
    a_cfg_hold: assert property (on |=> $stable(c)) else $error("cfg moved");
    a_off_quiet: assert property (
        ce_i && !port_enable_i |=> pin_en_o == 4'h0
    ) else $error("pins on");
    a_off_data: assert property (
        ce_i && !port_enable_i |=> pin_data_o == '0
    ) else $error("pin data on");
    c_two: cover property (on && c.two_lane);
    c_dsi: cover property (on && c.dsi_sel);
    c_trev: cover property (run && c.hdmi && c.reverse);
endmodule
bind lane_mapper lane_mapper_sva #(.SYM_W(SYM_W)) chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .port_enable_i(port_enable_i), .dsi_active_o(dsi_active_o), .cfg_i(cfg_i),
    .cfg_applied_o(cfg_applied_o), .enc_lane_i(enc_lane_i), .dsi_pin_i(dsi_pin_i),
    .pin_data_o(pin_data_o), .pin_en_o(pin_en_o));

// *** phy_model.sv ***
// Receiving lanes of the PHY behind the pins
`timescale 1ns/1ps
module phy_model #(parameter int SYM_W = 10) (
    input  wire logic                  mclk_i,
    input  wire logic [3:0][SYM_W-1:0] pin_data_i,
    input  wire logic [3:0]            pin_en_i,
    output logic      [3:0][SYM_W-1:0] rx_o
);
    // Undriven pin reads as a toggling pattern
    always_ff @(posedge mclk_i)
        for (int p = 0; p < 4; p++)
            rx_o[p] <= pin_en_i[p] ? pin_data_i[p] : ~rx_o[p];
endmodule

// *** testbench.sv ***
// Directed bench for the lane mapper
`timescale 1ns/1ps
module testbench;
    localparam int W = 10;
    logic mclk_i = 0, resetn_i = 0, en = 0, ce = 1, da;
    logic [4:0] ca;
    logic [4:0] cfg = 5'h00;
    logic [3:0][W-1:0] enc = {10'h2c3, 10'h1b2, 10'h0a1, 10'h390}, pd, rx;
    logic [3:0][W-1:0] dsi = {10'h3f7, 10'h0e6, 10'h2d5, 10'h1c4};
    logic [3:0] pe;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #2.5 mclk_i = ~mclk_i;
    lane_mapper #(.SYM_W(W)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce),
        .port_enable_i(en), .cfg_i(cfg), .enc_lane_i(enc), .dsi_pin_i(dsi),
        .pin_data_o(pd), .pin_en_o(pe), .cfg_applied_o(ca), .dsi_active_o(da));
    phy_model #(.SYM_W(W)) phy (.mclk_i(mclk_i), .pin_data_i(pd), .pin_en_i(pe), .rx_o(rx));
    task automatic cmp(input logic [W-1:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Code per pin: bit 2 picks the DSI source, bits 1:0 the lane
    task automatic run(input logic [4:0] c, a, input logic [11:0] m, input logic [3:0] e);
        en <= 1'b0;
        cfg <= c;
        repeat (2) @(posedge mclk_i);
        en <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        cmp(W'(pe), W'(e));
        cmp(W'(ca), W'(a));
        cmp(W'(da), W'(a[1]));
        for (int p = 0; p < 4; p++)
            if (e[p]) cmp(rx[p], m[p*3+2] ? dsi[m[p*3+:2]] : enc[m[p*3+:2]]);
        @(posedge mclk_i);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_dp;
        run(5'h00, 5'h00, 12'h688, 4'hf);
        run(5'h10, 5'h10, 12'h053, 4'hf);
        $display("test dp done");
    endtask
    task automatic t_tmds;
        run(5'h08, 5'h08, 12'h60a, 4'hf);
        run(5'h18, 5'h18, 12'h443, 4'hf);
        $display("test tmds done");
    endtask
    task automatic t_typec;
        run(5'h14, 5'h04, 12'h688, 4'hf);
        run(5'h07, 5'h05, 12'h688, 4'h3);
        $display("test typec done");
    endtask
    task automatic t_dsi;
        run(5'h02, 5'h02, 12'hfac, 4'hf);
        $display("test dsi done");
    endtask
    task automatic t_freeze;
        run(5'h00, 5'h00, 12'h688, 4'hf);
        cfg <= 5'h10;
        repeat (3) @(posedge mclk_i);
        #1;
        cmp(rx[0], enc[0]);
        cmp(W'(ca), W'(5'h00));
        @(posedge mclk_i);
        ce <= 1'b0;
        enc[0] <= 10'h155;
        repeat (3) @(posedge mclk_i);
        #1;
        cmp(rx[0], 10'h390);
        @(posedge mclk_i);
        ce <= 1'b1;
        enc[0] <= 10'h390;
        en <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        cmp(W'(pe), '0);
        cmp(W'(ca), W'(5'h10));
        @(posedge mclk_i);
        $display("test freeze done");
    endtask
    initial
    begin
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        t_dp;
        t_tmds;
        t_typec;
        t_dsi;
        t_freeze;
        report_and_stop;
    end
    always @(posedge mclk_i)
        if (++cyc > 500)
        begin
            n_mismatch++;
            report_and_stop;
        end
endmodule
